// ==== src/oecc_integrity.sv ====
`timescale 1ns/1ps
`default_nettype none
module oecc_integrity
  import oecc_pkg::*;
#(
  parameter int unsigned      SCAN_CYC      = SCAN_CYCLES,
  parameter int unsigned      FACT_WORDS    = 4,
  parameter logic [CRC_W-1:0] CRC_POLY      = CRC_POLY_DEF,
  parameter logic [CRC_W-1:0] CRC_INIT      = CRC_INIT_DEF,
  parameter bit               CRC_LSB_FIRST = 1'b0
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output var  logic                    s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output var  logic                    s_axi_wready,
  output var  logic [1:0]              s_axi_bresp,
  output var  logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output var  logic                    s_axi_arready,
  output var  logic [31:0]             s_axi_rdata,
  output var  logic [1:0]              s_axi_rresp,
  output var  logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output var  oecc_nvm_req_t           nvm_req,
  input  wire logic                    nvm_ack,
  input  wire logic [71:0]             nvm_rdata,
  input  wire logic [FACT_WORDS*32-1:0] fact_words
);

  localparam int FIW = (FACT_WORDS > 1) ? $clog2(FACT_WORDS) : 1;

  logic [ADDR_W-1:0] awaddr_q, araddr_q;
  logic [31:0]       wdata_q, rdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_held_q, w_held_q, bvalid_q, rvalid_q, arready_q;
  logic [1:0]        bresp_q, rresp_q, rd_ph_q;
  logic              wr_fire, rd_take, stat_rd;
  logic [3:0]        mem_we;
  logic [SH_IW-1:0]  mem_wa, mem_ra, scan_idx_q, ld_idx_q;
  logic [31:0]       mem_wd, mem_rd, rd_mux;
  oecc_ld_t          ld_q;
  oecc_scan_t        scan_q;
  oecc_nvm_req_t     nvm_q;
  oecc_ecc_res_t     ecc_now;
  logic [63:0]       blk_q;
  logic              last_blk, blk_sec, blk_ded, go_q;
  logic [2:0]        msel_q, sec_blk_q, ded_blk_q;
  logic              sec_q, ded_q, cmis_q, fmis_q, cdone_q, fdone_q;
  logic [7:0]        ref_hi_q, ref_lo_q;
  logic [CRC_W-1:0]  crc_q, cmp_q, fref_q;
  logic              cvld_q, fref_vld_q, scan_rd_q;
  logic [31:0]       tick_q;
  logic [FIW-1:0]    fidx_q;

  function automatic logic [CRC_W-1:0] crc_word(input logic [CRC_W-1:0] c, input logic [31:0] w);
    logic [CRC_W-1:0] r;
    logic             fb;
    r = c;
    for (int i = 0; i < 32; i++) begin
      fb = r[CRC_W-1] ^ (CRC_LSB_FIRST ? w[i] : w[31-i]);
      r  = {r[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    end
    return r;
  endfunction

  function automatic logic wr_hit(input logic [ADDR_W-1:0] off, input int bitpos);
    return wr_fire && awaddr_q == off && wstrb_q[0] && wdata_q[bitpos];
  endfunction

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  // Shadow writes wait while a load owns the memory port
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q && ld_q == L_IDLE;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= reg_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ************************************************************
  // Control and reference registers
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      msel_q   <= MSEL_RST;
      go_q     <= 1'b0;
      ref_hi_q <= REF_RST;
      ref_lo_q <= REF_RST;
    end else begin
      go_q <= wr_hit(OFF_CTRL, CTRL_GO_BIT);
      if (wr_fire && wstrb_q[0]) begin
        if (awaddr_q == OFF_CTRL) msel_q <= wdata_q[CTRL_MSEL_LSB +: 3];
        if (awaddr_q == OFF_REF_HI) ref_hi_q <= wdata_q[7:0];
        if (awaddr_q == OFF_REF_LO) ref_lo_q <= wdata_q[7:0];
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  // Phase 1 drives the memory address, phase 2 catches its registered data
  assign rd_take = s_axi_arvalid && arready_q;
  assign stat_rd = rd_ph_q == 2'd2 && araddr_q == OFF_STAT;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (araddr_q)
      OFF_CTRL:    rd_mux[CTRL_MSEL_LSB +: 3] = msel_q;
      OFF_STAT:    rd_mux[2:0] = {ld_q != L_IDLE, fdone_q, cdone_q};
      OFF_FAULT:   rd_mux[3:0] = {ded_q, sec_q, fmis_q, cmis_q};
      OFF_CMP_HI:  rd_mux[7:0] = cmp_q[15:8];
      OFF_CMP_LO:  rd_mux[7:0] = cmp_q[7:0];
      OFF_REF_HI:  rd_mux[7:0] = ref_hi_q;
      OFF_REF_LO:  rd_mux[7:0] = ref_lo_q;
      OFF_SEC_BLK: rd_mux[2:0] = sec_blk_q;
      OFF_DED_BLK: rd_mux[2:0] = ded_blk_q;
      default:     if (araddr_q <= OFF_SH_LAST) rd_mux = mem_rd;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      arready_q <= 1'b1;
      rd_ph_q   <= 2'd0;
      araddr_q  <= '0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      case (rd_ph_q)
        2'd0: if (rd_take) begin
          arready_q <= 1'b0;
          araddr_q  <= s_axi_araddr;
          rd_ph_q   <= 2'd1;
        end
        2'd1: rd_ph_q <= 2'd2;
        2'd2: begin
          rvalid_q <= 1'b1;
          rdata_q  <= reg_mapped(araddr_q) ? rd_mux : 32'h0000_0000;
          rresp_q  <= reg_mapped(araddr_q) ? RESP_OKAY : RESP_SLVERR;
          rd_ph_q  <= 2'd3;
        end
        default: if (s_axi_rready) begin
          rvalid_q  <= 1'b0;
          arready_q <= 1'b1;
          rd_ph_q   <= 2'd0;
        end
      endcase
    end
  end

  // ************************************************************
  // Shadow memory and its port sharing
  // ************************************************************
  always_comb begin
    mem_we = 4'h0;
    mem_wa = awaddr_q[5:2];
    mem_wd = wdata_q;
    case (ld_q)
      L_DEFLT: begin
        mem_we = 4'hf;
        mem_wa = ld_idx_q;
        mem_wd = SH_DEFAULT[ld_idx_q];
      end
      L_WR_LO: begin
        mem_we = 4'hf;
        mem_wa = {nvm_q.blk, 1'b0};
        mem_wd = blk_q[31:0];
      end
      L_WR_HI: begin
        mem_we = 4'hf;
        mem_wa = {nvm_q.blk, 1'b1};
        mem_wd = blk_q[63:32];
      end
      // An unaligned address answers SLVERR, so it must not touch the shadow either
      default: if (wr_fire && reg_mapped(awaddr_q) && awaddr_q <= OFF_SH_LAST) mem_we = wstrb_q;
    endcase
  end

  // A bus read wins the read port; the scan simply waits one cycle
  assign mem_ra = (rd_ph_q == 2'd1) ? araddr_q[5:2] : scan_idx_q;

  oecc_shadow_mem #(
    .DW    (32),
    .DEPTH (SH_WORDS),
    .AW    (SH_IW)
  ) u_mem (
    .clk_sys (clk_sys),
    .rst     (rst),
    .we      (mem_we),
    .waddr   (mem_wa),
    .wdata   (mem_wd),
    .raddr   (mem_ra),
    .rdata   (mem_rd)
  );

  // ************************************************************
  // Wakeup and margin load sequencer
  // ************************************************************
  assign ecc_now  = ecc_decode(nvm_rdata);
  assign last_blk = nvm_q.blk == BLK_IW'(NBLK - 1);
  assign blk_sec  = ld_q == L_WAIT && nvm_ack && ecc_now.sec;
  assign blk_ded  = ld_q == L_WAIT && nvm_ack && ecc_now.ded;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ld_q     <= L_DEFLT;
      ld_idx_q <= '0;
      nvm_q    <= '0;
      blk_q    <= '0;
    end else begin
      case (ld_q)
        L_IDLE: if (go_q) begin
          ld_q         <= L_REQ;
          nvm_q.blk    <= '0;
          nvm_q.margin <= msel_q;
        end
        L_DEFLT: if (ld_idx_q == SH_IW'(SH_WORDS - 1)) begin
          ld_q         <= L_REQ;
          nvm_q.blk    <= '0;
          nvm_q.margin <= MARGIN_NORMAL;
        end else begin
          ld_idx_q <= ld_idx_q + 4'h1;
        end
        L_REQ: begin
          nvm_q.req <= 1'b1;
          ld_q      <= L_WAIT;
        end
        L_WAIT: if (nvm_ack) begin
          nvm_q.req <= 1'b0;
          blk_q     <= ecc_now.data;
          if (!ecc_now.ded) begin
            ld_q <= L_WR_LO;
          end else if (last_blk) begin
            ld_q <= L_IDLE;
          end else begin
            ld_q      <= L_REQ;
            nvm_q.blk <= nvm_q.blk + 3'h1;
          end
        end
        L_WR_LO: ld_q <= L_WR_HI;
        L_WR_HI: if (last_blk) begin
          ld_q <= L_IDLE;
        end else begin
          ld_q      <= L_REQ;
          nvm_q.blk <= nvm_q.blk + 3'h1;
        end
        default: ld_q <= L_IDLE;
      endcase
    end
  end

  // Set wins over a clear landing in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sec_q     <= 1'b0;
      ded_q     <= 1'b0;
      sec_blk_q <= BLK_IDX_RST;
      ded_blk_q <= BLK_IDX_RST;
    end else begin
      sec_q <= (sec_q && !wr_hit(OFF_FAULT, FLT_SEC)) || blk_sec;
      ded_q <= (ded_q && !wr_hit(OFF_FAULT, FLT_DED)) || blk_ded;
      if (blk_sec) sec_blk_q <= nvm_q.blk;
      if (blk_ded) ded_blk_q <= nvm_q.blk;
    end
  end

  // ************************************************************
  // Background CRC scan
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scan_q     <= S_WAIT;
      tick_q     <= '0;
      scan_idx_q <= '0;
      scan_rd_q  <= 1'b0;
      fidx_q     <= '0;
    end else if (ld_q != L_IDLE) begin
      scan_q    <= S_WAIT; // A reload restarts the scan from scratch
      tick_q    <= '0;
      scan_rd_q <= 1'b0;
    end else begin
      scan_rd_q <= 1'b0;
      case (scan_q)
        S_WAIT: if (tick_q == 32'(SCAN_CYC - 1)) begin
          scan_q     <= S_CUST;
          tick_q     <= '0;
          scan_idx_q <= '0;
        end else begin
          tick_q <= tick_q + 32'h1;
        end
        S_CUST: if (rd_ph_q != 2'd1) begin
          scan_rd_q <= 1'b1;
          if (scan_idx_q == SH_IW'(SH_WORDS - 1)) scan_q <= S_CFIN;
          else scan_idx_q <= scan_idx_q + 4'h1;
        end
        S_CFIN:  scan_q <= S_CDONE;
        S_CDONE: begin
          scan_q <= S_FACT;
          fidx_q <= '0;
        end
        S_FACT: if (fidx_q == FIW'(FACT_WORDS - 1)) scan_q <= S_FDONE;
          else fidx_q <= fidx_q + FIW'(1);
        default: scan_q <= S_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      crc_q <= CRC_INIT;
    end else if (scan_rd_q) begin
      crc_q <= crc_word(crc_q, mem_rd);
    end else if (scan_q == S_FACT && ld_q == L_IDLE) begin
      crc_q <= crc_word(crc_q, fact_words[32*fidx_q +: 32]);
    end else if (scan_q == S_WAIT || scan_q == S_CDONE) begin
      crc_q <= CRC_INIT;
    end
  end

  // ************************************************************
  // Results, done bits and mismatch flags
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmp_q      <= '0;
      cvld_q     <= 1'b0;
      fref_q     <= '0;
      fref_vld_q <= 1'b0;
      cmis_q     <= 1'b0;
      fmis_q     <= 1'b0;
      cdone_q    <= 1'b0;
      fdone_q    <= 1'b0;
    end else begin
      if (scan_q == S_CDONE) begin
        cmp_q  <= crc_q;
        cvld_q <= 1'b1;
      end
      // First factory pass after reset is the baseline for later passes
      if (scan_q == S_FDONE && !fref_vld_q) begin
        fref_q     <= crc_q;
        fref_vld_q <= 1'b1;
      end
      cmis_q  <= cvld_q && cmp_q != {ref_hi_q, ref_lo_q};
      fmis_q  <= (fmis_q && !wr_hit(OFF_FAULT, FLT_FMIS)) ||
                 (scan_q == S_FDONE && fref_vld_q && crc_q != fref_q);
      cdone_q <= (cdone_q && !stat_rd) || scan_q == S_CDONE;
      fdone_q <= (fdone_q && !stat_rd) || scan_q == S_FDONE;
    end
  end

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign nvm_req       = nvm_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  fact_after_cust_a: assert property (scan_q == S_CDONE && ld_q == L_IDLE |=> scan_q == S_FACT)
    else $error("factory pass did not follow customer pass");
  result_capture_a: assert property (scan_q == S_CDONE |=> cmp_q == $past(crc_q))
    else $error("computed CRC not captured");
  done_hold_a: assert property (cdone_q && !stat_rd |=> cdone_q [*1])
    else $error("done bit dropped without a read");
  done_clear_a: assert property (stat_rd && scan_q != S_CDONE |=> !cdone_q)
    else $error("done bit not cleared by read");
  mismatch_level_a: assert property ((cvld_q && cmp_q != {ref_hi_q, ref_lo_q}) [*2] |-> cmis_q)
    else $error("mismatch flag not held");
  factory_flag_a: assert property (scan_q == S_FDONE && fref_vld_q && crc_q != fref_q |=> fmis_q)
    else $error("factory change not flagged");
  margin_start_a: assert property (go_q |=> ld_q == L_REQ && nvm_q.margin == $past(msel_q))
    else $error("margin reload not started");
  defaults_first_a: assert property (ld_q == L_DEFLT |-> !nvm_q.req && mem_we == 4'hf)
    else $error("block load before defaults");
  sec_record_a: assert property (blk_sec |=> sec_q && sec_blk_q == $past(nvm_q.blk) ##1 ld_q == L_WR_HI)
    else $error("corrected block not recorded");
  ded_skip_a: assert property (blk_ded |=> ded_q && ded_blk_q == $past(nvm_q.blk) && ld_q != L_WR_LO)
    else $error("double error block loaded");

endmodule
`default_nettype wire

// ==== src/oecc_pkg.sv ====
package oecc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int         ADDR_W       = 8;
  localparam int         SH_WORDS     = 12;
  localparam int         SH_IW        = 4;
  localparam logic [7:0] OFF_SH_FIRST = 8'h00;
  localparam logic [7:0] OFF_SH_LAST  = 8'h2f;
  localparam logic [7:0] OFF_CTRL     = 8'h30;
  localparam logic [7:0] OFF_STAT     = 8'h34;
  localparam logic [7:0] OFF_FAULT    = 8'h38;
  localparam logic [7:0] OFF_CMP_HI   = 8'h3c;
  localparam logic [7:0] OFF_CMP_LO   = 8'h40;
  localparam logic [7:0] OFF_REF_HI   = 8'h44;
  localparam logic [7:0] OFF_REF_LO   = 8'h48;
  localparam logic [7:0] OFF_SEC_BLK  = 8'h4c;
  localparam logic [7:0] OFF_DED_BLK  = 8'h50;

  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam int         CTRL_MSEL_LSB = 0;
  localparam int         CTRL_GO_BIT   = 3;
  localparam int         STAT_CDONE    = 0;
  localparam int         STAT_FDONE    = 1;
  localparam int         STAT_BUSY     = 2;
  localparam int         FLT_CMIS      = 0;
  localparam int         FLT_FMIS      = 1;
  localparam int         FLT_SEC       = 2;
  localparam int         FLT_DED       = 3;
  localparam logic [2:0] MSEL_RST      = 3'h0;
  localparam logic [2:0] MARGIN_NORMAL = 3'h0;
  localparam logic [7:0] REF_RST       = 8'h00;
  localparam logic [2:0] BLK_IDX_RST   = 3'h0;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  localparam logic [31:0] SH_DEFAULT [SH_WORDS] = '{default: 32'h0000_0000};

  // ************************************************************
  // Code and timing
  // ************************************************************
  localparam int          NBLK          = 6;
  localparam int          BLK_IW        = 3;
  localparam int          CRC_W         = 16;
  localparam logic [15:0] CRC_POLY_DEF  = 16'h1021;
  localparam logic [15:0] CRC_INIT_DEF  = 16'hffff;
  localparam int          CLK_PERIOD_PS = 5000;
  localparam int          SCAN_PERIOD_US = 100;
  localparam int          SCAN_CYCLES   = SCAN_PERIOD_US * 1000000 / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    L_IDLE  = 3'b000,
    L_DEFLT = 3'b001,
    L_REQ   = 3'b010,
    L_WAIT  = 3'b011,
    L_WR_LO = 3'b100,
    L_WR_HI = 3'b101
  } oecc_ld_t;

  typedef enum logic [2:0] {
    S_WAIT  = 3'b000,
    S_CUST  = 3'b001,
    S_CFIN  = 3'b010,
    S_CDONE = 3'b011,
    S_FACT  = 3'b100,
    S_FDONE = 3'b101
  } oecc_scan_t;

  typedef struct packed {
    logic        req;
    logic [2:0]  blk;
    logic [2:0]  margin;
  } oecc_nvm_req_t;

  typedef struct packed {
    logic [63:0] data;
    logic        sec;
    logic        ded;
  } oecc_ecc_res_t;

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) && (a <= OFF_DED_BLK);
  endfunction

  // Position 0 is overall parity, powers of two hold pN, data fill the rest
  function automatic oecc_ecc_res_t ecc_decode(input logic [71:0] cw);
    oecc_ecc_res_t r;
    logic [6:0]    syn;
    logic [71:0]   c;
    int            k;
    syn = '0;
    c   = cw;
    k   = 0;
    r   = '0;
    for (int i = 1; i < 72; i++) begin
      if (cw[i]) syn = syn ^ 7'(i);
    end
    if (^cw) begin
      if (syn < 7'd72) begin
        r.sec    = 1'b1;
        c[syn]   = ~c[syn];
      end else begin
        r.ded = 1'b1;
      end
    end else if (syn != 7'd0) begin
      r.ded = 1'b1;
    end
    for (int i = 3; i < 72; i++) begin
      if ((i & (i - 1)) != 0) begin
        r.data[k] = c[i];
        k++;
      end
    end
    return r;
  endfunction

endpackage

// ==== src/oecc_shadow_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module oecc_shadow_mem #(
  parameter int DW    = 32,
  parameter int DEPTH = 12,
  parameter int AW    = 4
) (
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic [DW/8-1:0] we,
  input  wire logic [AW-1:0]   waddr,
  input  wire logic [DW-1:0]   wdata,
  input  wire logic [AW-1:0]   raddr,
  output var  logic [DW-1:0]   rdata
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    for (int b = 0; b < DW / 8; b++) begin
      if (we[b]) mem[waddr][8*b +: 8] <= wdata[8*b +: 8];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) rdata <= '0;
    else rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

// ==== verification/oecc_integrity_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module oecc_integrity_bench
  import oecc_pkg::*;
;
  // ************************************************************
  // Signals
  // ************************************************************
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic          clk_sys = 1'b0, rst = 1'b1;
  logic          aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, nvm_ack = 1'b0;
  logic [7:0]    aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0]   w_d = 32'h0, r_d, seed = 32'hb837, sh [SH_WORDS];
  logic [71:0]   nvm_rdata = 72'h0, cw [NBLK];
  logic [127:0]  fact = 128'h0;
  logic          aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic [1:0]    b_resp, r_resp, bq [$];
  logic [2:0]    exp_m = MARGIN_NORMAL;
  logic [73:0]   rq [$];
  logic [15:0]   crc;
  oecc_nvm_req_t req;
  int            n_errors = 0, total_checks = 0, n_ack = 0;

  always #2.5 clk_sys = ~clk_sys;

  oecc_integrity #(.SCAN_CYC(16), .FACT_WORDS(4)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .nvm_req(req),
    .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .fact_words(fact));

  // ************************************************************
  // Models and helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [71:0] enc(input logic [63:0] d);
    logic [71:0] c;
    int          k;
    c = '0;
    k = 0;
    for (int i = 3; i < 72; i++) if ((i & (i - 1)) != 0) c[i] = d[k++];
    for (int p = 1; p < 72; p = p * 2) begin
      for (int i = p + 1; i < 72; i++) if ((i & p) != 0) c[p] = c[p] ^ c[i];
    end
    c[0] = ^c;
    return c;
  endfunction

  function automatic logic [15:0] crc_of();
    logic [15:0] c;
    c = CRC_INIT_DEF;
    for (int w = 0; w < SH_WORDS; w++) begin
      for (int b = 31; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ sh[w][b]) ? CRC_POLY_DEF : 16'h0);
    end
    return c;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic hang(input string what);
    $display("unexpected %s: expected an answer, seen none", what);
    n_errors++;
    give_verdict();
  endtask

  task automatic cmp(input string what, input logic [33:0] e, input logic [33:0] m, input logic [33:0] s);
    total_checks++;
    if (((e ^ s) & m) !== 34'h0) begin
      $display("unexpected %s: expected %h seen %h", what, e, s);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    bq.push_back(e);
    aw_a <= a;
    w_d  <= d;
    aw_v <= 1'b1;
    w_v  <= 1'b1;
    b_r  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (aw_rdy === 1'b1) aw_v <= 1'b0;
      if (w_rdy === 1'b1) w_v <= 1'b0;
      n++;
    end while (b_v !== 1'b1 && n < 300);
    b_r <= 1'b0;
    if (b_v !== 1'b1) hang("write");
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [31:0] m, output logic [31:0] d);
    int n;
    n = 0;
    rq.push_back({a, e, m});
    ar_a <= a;
    ar_v <= 1'b1;
    r_r  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (ar_rdy === 1'b1) ar_v <= 1'b0;
      n++;
    end while (r_v !== 1'b1 && n < 100);
    d = r_d;
    r_r <= 1'b0;
    if (r_v !== 1'b1) hang("read");
    @(posedge clk_sys);
  endtask

  // Status reads clear the done bits, so a poll consumes the event it waits for
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] d;
    int          n;
    d = ~v;
    for (n = 0; (d & m) !== v && n < 300; n++) rd(OFF_STAT, 34'h0, 32'h0, d);
    if (n >= 300) hang("status poll");
  endtask

  task automatic wait_ack(input int t);
    int n;
    for (n = 0; n_ack < t && n < 500; n++) @(posedge clk_sys);
    if (n >= 500) hang("block requests");
    poll(32'h4, 32'h0);
  endtask

  always @(posedge clk_sys) begin
    if (r_v === 1'b1 && r_r === 1'b1) cmp("read", rq[0][65:32], {2'h3, rq[0][31:0]}, {r_resp, r_d});
    if (r_v === 1'b1 && r_r === 1'b1) void'(rq.pop_front());
    if (b_v === 1'b1 && b_r === 1'b1) cmp("bresp", {32'h0, bq.pop_front()}, 34'h3, {32'h0, b_resp});
  end

  // Released block data is inverted each cycle so a stale word never passes
  always @(posedge clk_sys) begin
    if (req.req === 1'b1 && nvm_ack === 1'b0) begin
      cmp("nvm request", {28'h0, exp_m, 3'(n_ack % NBLK)}, 34'h3f, {28'h0, req.margin, req.blk});
      nvm_ack   <= 1'b1;
      nvm_rdata <= cw[req.blk];
      n_ack     <= n_ack + 1;
    end else begin
      nvm_ack   <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
    end
  end

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    logic [63:0] dat [NBLK];
    logic [31:0] tmp;
    for (int b = 0; b < NBLK; b++) begin
      dat[b] = {rnd(), rnd()};
      cw[b] = enc(dat[b]);
      {sh[2*b+1], sh[2*b]} = dat[b];
    end
    cw[1][10] = ~cw[1][10];
    cw[2] = cw[2] ^ 72'h00_0000_0100_0000_0020;
    cw[3][0] = ~cw[3][0];
    cw[4][64] = ~cw[4][64];
    sh[4] = SH_DEFAULT[4];
    sh[5] = SH_DEFAULT[5];
    fact = {rnd(), rnd(), rnd(), rnd()};
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    wait_ack(NBLK);
    for (int w = 0; w < SH_WORDS; w++) rd(8'(4 * w), {RESP_OKAY, sh[w]}, ALL, tmp);
    rd(OFF_FAULT, {RESP_OKAY, 32'hc}, 32'hc, tmp);
    rd(OFF_SEC_BLK, {RESP_OKAY, 32'h4}, ALL, tmp);
    rd(OFF_DED_BLK, {RESP_OKAY, 32'h2}, ALL, tmp);
    rd(8'h54, {RESP_SLVERR, 32'h0}, ALL, tmp);
    wr(8'h58, 32'h1, RESP_SLVERR);
    wr(8'h01, ~sh[0], RESP_SLVERR);
    rd(OFF_SH_FIRST, {RESP_OKAY, sh[0]}, ALL, tmp);
    $display("test wakeup load finished");
    sh[0] = rnd();
    wr(OFF_SH_FIRST, sh[0], RESP_OKAY);
    crc = crc_of();
    wr(OFF_REF_HI, {24'h0, crc[15:8]}, RESP_OKAY);
    wr(OFF_REF_LO, {24'h0, crc[7:0]}, RESP_OKAY);
    repeat (2) poll(32'h1, 32'h1);
    rd(OFF_STAT, {RESP_OKAY, 32'h0}, 32'h1, tmp);
    rd(OFF_CMP_HI, {RESP_OKAY, 24'h0, crc[15:8]}, ALL, tmp);
    rd(OFF_CMP_LO, {RESP_OKAY, 24'h0, crc[7:0]}, ALL, tmp);
    rd(OFF_FAULT, {RESP_OKAY, 32'h0}, 32'h1, tmp);
    wr(OFF_REF_LO, {24'h0, crc[7:0] ^ 8'h01}, RESP_OKAY);
    repeat (2) poll(32'h1, 32'h1);
    rd(OFF_FAULT, {RESP_OKAY, 32'h1}, 32'h1, tmp);
    $display("test customer crc finished");
    poll(32'h2, 32'h2);
    fact[5] <= ~fact[5];
    repeat (2) poll(32'h2, 32'h2);
    rd(OFF_FAULT, {RESP_OKAY, 32'h2}, 32'h2, tmp);
    wr(OFF_FAULT, 32'h2, RESP_OKAY);
    $display("test factory crc finished");
    wr(OFF_FAULT, 32'hc, RESP_OKAY);
    rd(OFF_FAULT, {RESP_OKAY, 32'h0}, 32'hc, tmp);
    exp_m <= 3'h1;
    sh[0] = dat[0][31:0];
    wr(OFF_CTRL, 32'h9, RESP_OKAY);
    wait_ack(2 * NBLK);
    rd(OFF_CTRL, {RESP_OKAY, 32'h1}, 32'hf, tmp);
    rd(OFF_FAULT, {RESP_OKAY, 32'hc}, 32'hc, tmp);
    for (int w = 0; w < 6; w++) rd(8'(4 * w), {RESP_OKAY, sh[w]}, ALL, tmp);
    $display("test margin reload finished");
    give_verdict();
  end
endmodule
`default_nettype wire
